// ### inc/eeprom_pkg.sv
package eeprom_pkg;

  // ******************************************
  // Array geometry
  // ******************************************
  localparam int WORD_BITS = 16;
  localparam int WORD_COUNT = 16;
  localparam int ADDR_BITS = 4;

  // ******************************************
  // Instruction layout
  // ******************************************
  localparam int INSTR_BITS = 9;
  localparam int INSTR_LEAD_POS = 8;
  localparam int OPC_MSB = 7;
  localparam int OPC_LSB = 4;
  localparam int ADR_MSB = 3;
  localparam int ADR_LSB = 0;

  localparam logic [3:0] OPC_ERASE_ALL = 4'h2;
  localparam logic [3:0] OPC_WORD_ERASE = 4'hC;
  localparam logic [3:0] OPC_WRITE = 4'h4;
  localparam logic [3:0] OPC_READ = 4'h8;

  // ******************************************
  // Values after reset and erase
  // ******************************************
  localparam logic [INSTR_BITS-1:0] INSTR_EMPTY = 9'h000;
  localparam logic [WORD_BITS-1:0] DATA_EMPTY = 16'h0000;
  localparam logic [WORD_BITS-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [4:0] BIT_COUNT_RST = 5'h00;

  // ******************************************
  // Timing and buffer size
  // ******************************************
  localparam int CLOCK_HZ = 100_000_000;
  localparam int EW_TIME_MS = 20;
  localparam int EW_CYCLES = EW_TIME_MS * (CLOCK_HZ / 1000);
  localparam int SYNC_STAGES = 3;
  localparam int BUF_ENTRIES = 2;

  // ******************************************
  // Sequencer states
  // ******************************************
  typedef enum logic [4:0] {
    ST_COLLECT = 5'h01,
    ST_FETCH = 5'h02,
    ST_READOUT = 5'h04,
    ST_ARMED = 5'h08,
    ST_BUSY = 5'h10
  } op_state_t;

endpackage : eeprom_pkg

// ### inc/array_if.sv
`timescale 1ns/100ps
interface array_if;
  import eeprom_pkg::*;
  logic rd_en;
  logic [ADDR_BITS-1:0] addr;
  logic [WORD_BITS-1:0] rd_data;
  logic rd_valid;
  logic wr_en;
  logic [WORD_BITS-1:0] wr_data;
  logic erase_all;

  modport ctrl (
    output rd_en, addr, wr_en, wr_data, erase_all,
    input rd_data, rd_valid
  );
  modport mem (
    input rd_en, addr, wr_en, wr_data, erase_all,
    output rd_data, rd_valid
  );
endinterface : array_if

// ### design/word_array.sv
`timescale 1ns/100ps
module word_array
  import eeprom_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Array port
  array_if.mem arr
);

  // ******************************************
  // Storage
  // ******************************************
  // Contents are not reset: they model nonvolatile cells
  logic [WORD_BITS-1:0] word_reg [WORD_COUNT];
  logic [WORD_BITS-1:0] rd_data_reg;
  logic rd_valid_reg;

  genvar w;
  for (w = 0; w < WORD_COUNT; w++) begin : g_word
    always_ff @(posedge i_clock) begin
      if (arr.erase_all) begin
        word_reg[w] <= ERASED_WORD;  // [RULE_18]
      end else if (arr.wr_en && (arr.addr == ADDR_BITS'(w))) begin
        word_reg[w] <= arr.wr_data;  // [RULE_17]
      end
    end
  end

  // ******************************************
  // Registered read
  // ******************************************
  always_ff @(posedge i_clock) begin
    if (arr.rd_en) begin
      rd_data_reg <= word_reg[arr.addr];  // [RULE_13]
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= arr.rd_en;
    end
  end

  assign arr.rd_data = rd_data_reg;
  assign arr.rd_valid = rd_valid_reg;

endmodule : word_array

// ### design/serial_eeprom.sv
`timescale 1ns/100ps
// Operation
// RULE_01 - Array holds sixteen 16-bit words at 4-bit addresses.
// RULE_02 - Serial input bits are sampled on each shift clock rising edge.
// RULE_03 - Read data on serial output moves only on shift clock rises.
// RULE_04 - Instruction is nine bits: lead marker, four opcode, four address.
// RULE_05 - Lead marker in last shifter stage stops further instruction shifting.
// RULE_06 - Erase, erase-all and write start on select falling edge.
// RULE_07 - Operation is self-timed; all shifting ignored until it ends.
// RULE_08 - Outside reads output is high when ready, low when busy.
// RULE_09 - Controller polls completion by selecting and watching the output.
// RULE_10 - Instruction shifter clears at operation end and at select fall.
// RULE_11 - Reset empties both instruction and data shifters.
// RULE_12 - Controller drops select for a period before each new instruction.
// RULE_13 - Decoded read copies the addressed word into data shifter.
// RULE_14 - Output is low during the read pulse as dummy lead bit.
// RULE_15 - Next clocks shift sixteen data bits out, most significant first.
// RULE_16 - Word erase sets the word to ones; erase precedes writing.
// RULE_17 - Word erase touches only the addressed word.
// RULE_18 - Erase-all behaves as word erase but sets every word.
// RULE_19 - Controller shifts exactly sixteen data bits after write instruction.
// RULE_20 - Opcodes: 0010 erase-all, 1100 erase, 0100 write, 1000 read.
// RULE_21 - Erase or write completes within 20 ms, then ready shows.
// RULE_22 - Select is active high; low level means deselected standby.
module serial_eeprom
  import eeprom_pkg::*;
#(
  parameter int EW_CYCLES_P = EW_CYCLES,
  parameter int BUF_DEPTH = BUF_ENTRIES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Serial pins from the controller
  input wire logic i_select,
  input wire logic i_shift_clock_pin,
  input wire logic i_serial_in_pin,
  // Serial output pin
  output logic o_serial_out,
  output logic o_serial_out_en
);

  // ******************************************
  // Derived widths
  // ******************************************
  localparam int TW = $clog2(EW_CYCLES_P + 1);
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = $clog2(BUF_DEPTH + 1);

  // ******************************************
  // Declarations
  // ******************************************
  logic [2:0] pin_raw;
  logic [2:0] pin_lvl;
  logic sel_lvl;
  logic sk_lvl;
  logic di_lvl;
  logic sel_prev_reg;
  logic sk_prev_reg;
  logic sk_rise;
  logic sel_fall;
  logic shift_ok;

  op_state_t state_reg;
  op_state_t state_next;

  logic [INSTR_BITS-1:0] instr_reg;
  logic instr_full;
  logic [3:0] opcode;
  logic [ADDR_BITS-1:0] word_addr;
  logic op_is_read;
  logic op_is_write;
  logic op_is_erase;
  logic op_is_erase_all_words;
  logic op_launches;

  logic [WORD_BITS-1:0] data_reg;
  logic [4:0] bit_count_reg;
  logic dummy_reg;
  logic [TW-1:0] ew_count_reg;
  logic ew_done;
  logic launch;
  logic read_pulse;

  logic [WORD_BITS-1:0] buf_mem_reg [BUF_DEPTH];
  logic [PW-1:0] buf_wr_ptr_reg;
  logic [PW-1:0] buf_rd_ptr_reg;
  logic [CW-1:0] buf_count_reg;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic buf_push;
  logic buf_pop;
  logic buf_flush;

  logic serial_out_reg;
  logic serial_out_next;
  logic serial_out_en_reg;

  array_if arr ();

  // ******************************************
  // Pin synchronisers
  // ******************************************
  // A level counts once the second and third stages agree,
  // which rejects single-sample glitches on slow pin edges
  assign pin_raw = {i_select, i_shift_clock_pin, i_serial_in_pin};

  genvar g;
  for (g = 0; g < 3; g++) begin : g_sync
    logic [SYNC_STAGES-1:0] chain_reg;
    logic lvl_reg;
    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        chain_reg <= '0;
      end else begin
        chain_reg <= {chain_reg[SYNC_STAGES-2:0], pin_raw[g]};
      end
    end
    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        lvl_reg <= 1'b0;
      end else if (chain_reg[1] == chain_reg[2]) begin
        lvl_reg <= chain_reg[2];
      end
    end
    assign pin_lvl[g] = lvl_reg;
  end

  assign sel_lvl = pin_lvl[2];
  assign sk_lvl = pin_lvl[1];
  assign di_lvl = pin_lvl[0];

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sel_prev_reg <= 1'b0;
      sk_prev_reg <= 1'b0;
    end else begin
      sel_prev_reg <= sel_lvl;
      sk_prev_reg <= sk_lvl;
    end
  end

  assign sk_rise = sk_lvl & ~sk_prev_reg;  // [RULE_02]
  assign sel_fall = ~sel_lvl & sel_prev_reg;
  // No shifting while deselected or during a timed operation
  assign shift_ok = sel_lvl & sk_rise & (state_reg != ST_BUSY);  // [RULE_07] [RULE_22]

  // ******************************************
  // Instruction decode
  // ******************************************
  assign instr_full = instr_reg[INSTR_LEAD_POS];
  assign opcode = instr_reg[OPC_MSB:OPC_LSB];
  assign word_addr = instr_reg[ADR_MSB:ADR_LSB];
  assign op_is_read = (opcode == OPC_READ);  // [RULE_20]
  assign op_is_write = (opcode == OPC_WRITE);
  assign op_is_erase = (opcode == OPC_WORD_ERASE);
  assign op_is_erase_all_words = (opcode == OPC_ERASE_ALL);
  assign op_launches = op_is_write | op_is_erase | op_is_erase_all_words;

  // ******************************************
  // Instruction shifter
  // ******************************************
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      instr_reg <= INSTR_EMPTY;  // [RULE_11]
    end else if (ew_done) begin
      instr_reg <= INSTR_EMPTY;  // [RULE_10]
    end else if (sel_fall && !launch) begin
      instr_reg <= INSTR_EMPTY;  // [RULE_10] [RULE_12]
    end else if (shift_ok && !instr_full) begin
      instr_reg <= {instr_reg[INSTR_BITS-2:0], di_lvl};  // [RULE_04] [RULE_05]
    end
  end

  // ******************************************
  // Sequencer
  // ******************************************
  assign launch = sel_fall & (state_reg == ST_ARMED);  // [RULE_06]
  // Read pulse waits for buffer room, so the array never overruns it
  assign read_pulse = (state_reg == ST_COLLECT) & instr_full & op_is_read & buf_in_ready & ~sel_fall;  // [RULE_13]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_COLLECT: begin
        if (read_pulse) begin
          state_next = ST_FETCH;
        end else if (instr_full && op_launches && !sel_fall) begin
          state_next = ST_ARMED;
        end
      end
      ST_FETCH: begin
        if (sel_fall) begin
          state_next = ST_COLLECT;
        end else if (buf_out_valid) begin
          state_next = ST_READOUT;
        end
      end
      ST_READOUT: begin
        if (sel_fall) begin
          state_next = ST_COLLECT;
        end
      end
      ST_ARMED: begin
        if (sel_fall) begin
          state_next = ST_BUSY;  // [RULE_06]
        end
      end
      ST_BUSY: begin
        if (ew_done) begin
          state_next = ST_COLLECT;
        end
      end
      default: begin
        state_next = ST_COLLECT;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_reg <= ST_COLLECT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ******************************************
  // Erase and write timer
  // ******************************************
  assign ew_done = (state_reg == ST_BUSY) && (ew_count_reg == '0);  // [RULE_21]

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ew_count_reg <= '0;
    end else if (launch) begin
      ew_count_reg <= TW'(EW_CYCLES_P - 1);  // [RULE_07] [RULE_21]
    end else if ((state_reg == ST_BUSY) && (ew_count_reg != '0)) begin
      ew_count_reg <= ew_count_reg - TW'(1);
    end
  end

  // ******************************************
  // Array commit and read
  // ******************************************
  // Commit happens at the end of the timed interval, so an
  // aborted power cycle mid-operation leaves the array intact
  assign arr.rd_en = read_pulse;
  assign arr.addr = word_addr;  // [RULE_01]
  assign arr.wr_en = ew_done & (op_is_write | op_is_erase);
  assign arr.wr_data = op_is_write ? data_reg : ERASED_WORD;  // [RULE_16]
  assign arr.erase_all = ew_done & op_is_erase_all_words;  // [RULE_18]

  word_array u_word_array (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .arr(arr.mem)
  );

  // ******************************************
  // Two-entry read buffer
  // ******************************************
  assign buf_in_valid = arr.rd_valid;
  assign buf_in_ready = (buf_count_reg < CW'(BUF_DEPTH));
  assign buf_out_valid = (buf_count_reg != '0);
  assign buf_out_ready = (state_reg == ST_FETCH) & ~sel_fall;
  // Deselect drops stale words so the next read sees only its own
  assign buf_flush = sel_fall;
  assign buf_push = buf_in_valid & buf_in_ready & ~buf_flush;
  assign buf_pop = buf_out_valid & buf_out_ready;

  always_ff @(posedge i_clock) begin
    if (buf_push) begin
      buf_mem_reg[buf_wr_ptr_reg] <= arr.rd_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst || buf_flush) begin
      buf_wr_ptr_reg <= '0;
      buf_rd_ptr_reg <= '0;
      buf_count_reg <= '0;
    end else begin
      if (buf_push) begin
        buf_wr_ptr_reg <= (buf_wr_ptr_reg == PW'(BUF_DEPTH - 1)) ? '0 : buf_wr_ptr_reg + PW'(1);
      end
      if (buf_pop) begin
        buf_rd_ptr_reg <= (buf_rd_ptr_reg == PW'(BUF_DEPTH - 1)) ? '0 : buf_rd_ptr_reg + PW'(1);
      end
      if (buf_push && !buf_pop) begin
        buf_count_reg <= buf_count_reg + CW'(1);
      end else if (buf_pop && !buf_push) begin
        buf_count_reg <= buf_count_reg - CW'(1);
      end
    end
  end

  // ******************************************
  // Data shifter
  // ******************************************
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      data_reg <= DATA_EMPTY;  // [RULE_11]
    end else if (buf_pop) begin
      data_reg <= buf_mem_reg[buf_rd_ptr_reg];  // [RULE_13]
    end else if ((state_reg == ST_READOUT) && shift_ok && !dummy_reg) begin
      data_reg <= {data_reg[WORD_BITS-2:0], 1'b0};  // [RULE_15]
    end else if ((state_reg == ST_ARMED) && op_is_write && shift_ok &&
                 (bit_count_reg < 5'(WORD_BITS))) begin
      data_reg <= {data_reg[WORD_BITS-2:0], di_lvl};
    end
  end

  // Extra bits beyond one word are ignored
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || (state_reg != ST_ARMED)) begin
      bit_count_reg <= BIT_COUNT_RST;
    end else if (op_is_write && shift_ok && (bit_count_reg < 5'(WORD_BITS))) begin
      bit_count_reg <= bit_count_reg + 5'h01;
    end
  end

  // Dummy bit stands until the first clock rise after the load
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      dummy_reg <= 1'b0;
    end else if (buf_pop) begin
      dummy_reg <= 1'b1;  // [RULE_14]
    end else if ((state_reg == ST_READOUT) && shift_ok) begin
      dummy_reg <= 1'b0;  // [RULE_15]
    end
  end

  // ******************************************
  // Serial output
  // ******************************************
  always_comb begin
    case (state_reg)
      ST_FETCH: begin
        serial_out_next = 1'b0;  // [RULE_14]
      end
      ST_READOUT: begin
        serial_out_next = dummy_reg ? 1'b0 : data_reg[WORD_BITS-1];  // [RULE_03] [RULE_15]
      end
      ST_BUSY: begin
        serial_out_next = ew_done;  // [RULE_08]
      end
      default: begin
        serial_out_next = 1'b1;  // [RULE_08]
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      serial_out_reg <= 1'b1;
      serial_out_en_reg <= 1'b0;
    end else begin
      serial_out_reg <= serial_out_next;
      serial_out_en_reg <= sel_lvl;  // [RULE_22]
    end
  end

  assign o_serial_out = serial_out_reg;
  assign o_serial_out_en = serial_out_en_reg;

endmodule : serial_eeprom

// ### tb/serial_eeprom_sva.sv
`timescale 1ns/100ps
module serial_eeprom_sva
  import eeprom_pkg::*;
#(
  parameter int EW_CYCLES_P = EW_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_select,
  input wire logic i_shift_clock_pin,
  input wire logic i_serial_in_pin,
  input wire logic o_serial_out,
  input wire logic o_serial_out_en
);
  // ****************
  // Raw-pin shadow
  // ****************
  logic sk_reg;
  logic sel_reg;
  logic [8:0] ins_reg;
  int busy_reg;
  logic [7:0] since_sk_reg;
  logic sk_rise;
  logic rd_mode;
  assign sk_rise = i_shift_clock_pin && !sk_reg;
  assign rd_mode = ins_reg[8] && ins_reg[7:4] == OPC_READ && i_select;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sk_reg <= 1'b0;
      sel_reg <= 1'b0;
      since_sk_reg <= 8'h00;
    end else begin
      sk_reg <= i_shift_clock_pin;
      sel_reg <= i_select;
      since_sk_reg <= sk_rise ? 8'h00 : since_sk_reg + {7'h00, since_sk_reg != 8'hFF};
    end
  end
  // Shadow leads the design by its pin sync, hence slack below
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ins_reg <= 9'h000;
      busy_reg <= 0;
    end else begin
      busy_reg <= (busy_reg != 0) ? busy_reg - 1 : 0;
      if (sel_reg && !i_select) begin
        ins_reg <= 9'h000;
        if (ins_reg[8] && ins_reg[7:4] != OPC_READ) begin
          busy_reg <= EW_CYCLES_P;
        end
      end else if (sk_rise && i_select && busy_reg == 0 && !ins_reg[8]) begin
        ins_reg <= {ins_reg[7:0], i_serial_in_pin};
      end
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_reset_outputs: assert property (disable iff (1'b0) i_sys_rst |=> o_serial_out && !o_serial_out_en)
    else $error("outputs not idle after reset");
  a_enable_on_select: assert property ($rose(i_select) |-> ##[3:8] o_serial_out_en)
    else $error("enable late after select");
  a_enable_off_deselect: assert property ($fell(i_select) |-> ##[3:8] !o_serial_out_en)
    else $error("enable stays after deselect");
  a_quiet_deselected: assert property (!i_select [*8] |-> !o_serial_out_en)
    else $error("output driven while deselected");
  a_dummy_bit_low: assert property ($rose(ins_reg[8]) && ins_reg[7:4] == OPC_READ |-> ##[3:10] !o_serial_out)
    else $error("no low dummy bit");
  a_read_out_stable: assert property (rd_mode && $past(rd_mode) && since_sk_reg > 8'h0C |-> $stable(o_serial_out))
    else $error("read output moved without shift clock");
  a_busy_reads_low: assert property (busy_reg != 0 && busy_reg < EW_CYCLES_P - 10 && o_serial_out_en |-> !o_serial_out)
    else $error("ready shown while busy");
  a_ready_after_timer: assert property (busy_reg == 1 |-> ##[1:12] o_serial_out)
    else $error("ready late after timer");
  c_read_dummy: cover property ($rose(ins_reg[8]) && ins_reg[7:4] == OPC_READ);
  c_launch: cover property (busy_reg == EW_CYCLES_P);
  c_poll_busy: cover property (busy_reg != 0 && o_serial_out_en);
endmodule : serial_eeprom_sva
bind serial_eeprom serial_eeprom_sva #(.EW_CYCLES_P(EW_CYCLES_P)) serial_eeprom_sva_i (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_select(i_select), .i_shift_clock_pin(i_shift_clock_pin),
  .i_serial_in_pin(i_serial_in_pin), .o_serial_out(o_serial_out), .o_serial_out_en(o_serial_out_en));

// ### tb/serial_host.sv
`timescale 1ns/100ps
module serial_host
  import eeprom_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_serial_out,
  output logic o_select,
  output logic o_shift_clock_pin,
  output logic o_serial_in_pin
);
  initial begin
    o_select = 1'b0;
    o_shift_clock_pin = 1'b0;
    o_serial_in_pin = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask : wait_cyc
  // Line released after hold: show inverse, never the old bit
  task automatic send_bit(input logic b);
    wait_cyc(1);
    o_serial_in_pin <= b;
    wait_cyc(12);
    o_shift_clock_pin <= 1'b1;
    wait_cyc(12);
    o_shift_clock_pin <= 1'b0;
    o_serial_in_pin <= ~b;
  endtask : send_bit
  task automatic set_select(input logic v);
    o_select <= v;
    wait_cyc(12);
  endtask : set_select
  task automatic send_instr(input logic [3:0] op, input logic [3:0] adr);
    logic [8:0] v;
    v = {1'b1, op, adr};
    for (int i = 8; i >= 0; i--) send_bit(v[i]);
  endtask : send_instr
  task automatic send_word(input logic [15:0] d);
    for (int i = 15; i >= 0; i--) send_bit(d[i]);
  endtask : send_word
  task automatic read_word(output logic dmy, output logic [15:0] q);
    dmy = i_serial_out;
    for (int i = 15; i >= 0; i--) begin
      send_bit(1'b0);
      q[i] = i_serial_out;
    end
  endtask : read_word
  task automatic poll_ready(output logic ok);
    int n;
    set_select(1'b1);
    n = 0;
    while (i_serial_out !== 1'b1 && n < 400) begin
      wait_cyc(1);
      n++;
    end
    ok = n < 400;
    set_select(1'b0);
  endtask : poll_ready
  task automatic run_cmd(input logic [3:0] op, input logic [3:0] adr, input logic [15:0] d,
                         output logic dmy, output logic [15:0] q, output logic ok);
    dmy = 1'b1;
    q = 16'h0000;
    ok = 1'b1;
    set_select(1'b1);
    send_instr(op, adr);
    if (op == OPC_WRITE) send_word(d);
    if (op == OPC_READ) read_word(dmy, q);
    set_select(1'b0);
    if (op != OPC_READ) poll_ready(ok);
  endtask : run_cmd
endmodule : serial_host

// ### tb/serial_eeprom_tb.sv
`timescale 1ns/100ps
module serial_eeprom_tb;
  import eeprom_pkg::*;
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] adr;
    logic [15:0] dat;
  } row_t;
  logic i_clock;
  logic i_sys_rst;
  logic sel;
  logic sk;
  logic di;
  logic o_serial_out;
  logic o_serial_out_en;
  logic dmy;
  logic [15:0] q;
  logic ok;
  logic do_seen;
  logic [3:0] h_adr = 4'h7;
  logic [15:0] h_dat = 16'h8001;
  int fail_count = 0;
  int tests_run = 0;
  // Read rows carry the expected word
  row_t rows[10] = '{'{OPC_ERASE_ALL, 4'h0, 16'h0000}, '{OPC_READ, 4'h5, 16'hFFFF},
    '{OPC_WRITE, 4'h3, 16'hA5C3}, '{OPC_WRITE, 4'hF, 16'h1234}, '{OPC_READ, 4'h3, 16'hA5C3},
    '{OPC_READ, 4'hF, 16'h1234}, '{OPC_WORD_ERASE, 4'h3, 16'h0000}, '{OPC_READ, 4'h3, 16'hFFFF},
    '{OPC_READ, 4'hF, 16'h1234}, '{OPC_READ, 4'h0, 16'hFFFF}};
  serial_eeprom #(.EW_CYCLES_P(50), .BUF_DEPTH(2)) serial_eeprom_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_select(sel), .i_shift_clock_pin(sk), .i_serial_in_pin(di), .o_serial_out(o_serial_out),
    .o_serial_out_en(o_serial_out_en));
  // No pull on the line: a released pin reads as the inverse of its last level
  assign do_seen = o_serial_out_en ? o_serial_out : ~o_serial_out;
  serial_host serial_host_i (.i_clock(i_clock), .i_serial_out(do_seen), .o_select(sel),
    .o_shift_clock_pin(sk), .o_serial_in_pin(di));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset();
    i_sys_rst <= 1'b1;
    repeat (3) @(negedge i_clock);
    i_sys_rst <= 1'b0;
    @(negedge i_clock);
    check({14'h0000, o_serial_out, o_serial_out_en}, 16'h0002);
    repeat (8) @(negedge i_clock);
  endtask : do_reset
  initial begin
    #500_000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    i_sys_rst = 1'b1;
    do_reset();
    for (int k = 0; k < 10; k++) begin
      serial_host_i.run_cmd(rows[k].op, rows[k].adr, rows[k].dat, dmy, q, ok);
      if (rows[k].op == OPC_READ) begin
        check({15'h0000, dmy}, 16'h0000);
        check(q, rows[k].dat);
      end else begin
        check({15'h0000, ok}, 16'h0001);
      end
    end
    // ****************
    // Poll and shift while busy
    // ****************
    serial_host_i.set_select(1'b1);
    serial_host_i.send_instr(rows[2].op, h_adr);
    serial_host_i.send_word(h_dat);
    serial_host_i.set_select(1'b0);
    serial_host_i.set_select(1'b1);
    check({14'h0000, o_serial_out, o_serial_out_en}, 16'h0001);
    serial_host_i.send_bit(h_dat[15]);
    serial_host_i.poll_ready(ok);
    check({15'h0000, ok}, 16'h0001);
    serial_host_i.send_bit(h_dat[0]);
    serial_host_i.send_bit(h_dat[1]);
    serial_host_i.run_cmd(rows[1].op, h_adr, h_dat, dmy, q, ok);
    check(q, h_dat);
    // ****************
    // Overlong read, then deselect
    // ****************
    serial_host_i.set_select(1'b1);
    serial_host_i.send_instr(rows[5].op, rows[5].adr);
    serial_host_i.read_word(dmy, q);
    check(q, rows[5].dat);
    serial_host_i.send_bit(1'b0);
    check({15'h0000, o_serial_out}, 16'h0000);
    serial_host_i.set_select(1'b0);
    check({14'h0000, o_serial_out, o_serial_out_en}, 16'h0002);
    // ****************
    // Second reset keeps the array
    // ****************
    do_reset();
    serial_host_i.run_cmd(rows[5].op, rows[5].adr, rows[5].dat, dmy, q, ok);
    check(q, rows[5].dat);
    tally_and_finish();
  end
endmodule : serial_eeprom_tb
